// File: rtl/risc_instruction_decoder.sv
// Instruction decoder stage with its own status word and AHB-Lite regs.
// Assumes fetch offers one word with its address; execute writes back.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`default_nettype none

module risc_instruction_decoder import decoder_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [WORD_W-1:0] instr_word,
  input wire logic [WORD_W-1:0] instr_pc,
  input wire logic wb_en,
  input wire logic [SEL_W-1:0] wb_sel,
  input wire logic [WORD_W-1:0] wb_data,
  input wire logic carry_wr,
  input wire logic carry_val,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output decoded_type dec_out,
  output logic [WORD_W-1:0] msw_out
);
  logic [WORD_W-1:0] ctrl;
  logic [WORD_W-1:0] decode_count;
  logic pfx_pending;
  logic [HALF_W-1:0] pfx_value;
  logic take;
  logic [WORD_W-1:0] imm0;
  logic s1_valid;
  logic [WORD_W-1:0] s1_instr;
  logic [WORD_W-1:0] s1_pc;
  logic [WORD_W-1:0] s1_imm;
  logic s1_pfx_used;
  logic [HALF_W-1:0] s1_pfx_val;
  logic [WORD_W-1:0] src_a_val;
  logic [WORD_W-1:0] src_b_val;
  logic [5:0] opc1;
  logic [SEL_W-1:0] dst1;
  logic [SEL_W-1:0] srca1;
  logic [14:0] low1;
  logic fmt1;
  logic cond_true;
  logic is_to_spr;
  logic is_ret;
  decoded_type next_dec;
  logic [WORD_W-1:0] next_msw;
  logic dp_active;
  logic dp_write;
  logic [REG_AW-1:0] dp_addr;
  logic addr_ok;
  logic [REG_AW-1:0] a_off;
  logic ctrl_wr;
  logic [WORD_W-1:0] ctrl_view;
  logic [WORD_W-1:0] next_rdata;

  // Instruction is taken only while decoding is enabled by software
  assign take = instr_valid && ctrl[CTRL_EN_BIT];

  // Immediate widening for the incoming word
  imm_extend u_imm (
    .imm_half(instr_word[IMM_HI:IMM_LO]),
    .pfx_pending(pfx_pending),
    .pfx_value(pfx_value),
    .imm_full(imm0)
  );

  // Operands read at take; data arrive with stage one
  register_file u_regs (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .a_sel(instr_word[SRCA_HI:SRCA_LO]),
    .b_sel(instr_word[SRCB_HI:SRCB_LO]),
    .wr_en(wb_en),
    .wr_sel(wb_sel),
    .wr_data(wb_data),
    .a_data(src_a_val),
    .b_data(src_b_val)
  );

  // Prefix holder; any other taken word consumes or discards it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pfx_pending <= 1'b0;
      pfx_value <= '0;
    end else if (take) begin
      if (instr_word[OPC_HI:OPC_LO] == OPC_PREFIX) begin
        pfx_pending <= 1'b1;
        pfx_value <= instr_word[IMM_HI:IMM_LO];
      end else begin
        pfx_pending <= 1'b0;
      end
    end
  end

  // Stage one: hold the word while its operands are read
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s1_valid <= 1'b0;
      s1_instr <= '0;
      s1_pc <= '0;
      s1_imm <= '0;
      s1_pfx_used <= 1'b0;
      s1_pfx_val <= '0;
    end else begin
      s1_valid <= take && (instr_word[OPC_HI:OPC_LO] != OPC_PREFIX);
      s1_instr <= instr_word;
      s1_pc <= instr_pc;
      s1_imm <= imm0;
      s1_pfx_used <= pfx_pending && instr_word[FMT_BIT];
      s1_pfx_val <= pfx_value;
    end
  end

  // Field split with bit 0 as the most significant bit
  assign opc1 = s1_instr[OPC_HI:OPC_LO];
  assign dst1 = s1_instr[DST_HI:DST_LO];
  assign srca1 = s1_instr[SRCA_HI:SRCA_LO];
  assign low1 = s1_instr[LOW_HI:LOW_LO];
  assign fmt1 = s1_instr[FMT_BIT];
  assign is_to_spr = s1_valid && opc1 == OPC_SPR && low1 == LOW_TO_SPR;
  assign is_ret = s1_valid && opc1 == OPC_RET;

  // Signed compare of source one against zero
  always_comb begin
    unique case (dst1[2:0])
      CND_EQ: cond_true = src_a_val == '0;
      CND_NE: cond_true = src_a_val != '0;
      CND_LT: cond_true = src_a_val[WORD_W-1];
      CND_LE: cond_true = src_a_val[WORD_W-1] || src_a_val == '0;
      CND_GT: cond_true = !src_a_val[WORD_W-1] && src_a_val != '0;
      CND_GE: cond_true = !src_a_val[WORD_W-1];
      default: cond_true = 1'b0;
    endcase
  end

  // Decode proper: operands, results, branches, memory access
  always_comb begin
    next_dec = '0;
    next_dec.valid = s1_valid;
    next_dec.imm_format = fmt1;
    next_dec.opcode = opc1;
    next_dec.dst_sel = dst1;
    next_dec.src_a_sel = srca1;
    next_dec.src_b_sel = fmt1 ? ZERO_REG : s1_instr[SRCB_HI:SRCB_LO];
    next_dec.operand_a = src_a_val;
    next_dec.imm_valid = fmt1;
    next_dec.operand_b = fmt1 ? s1_imm : src_b_val;
    case (opc1)
      OPC_SEXT: begin
        if (low1 == LOW_SEXT) begin
          next_dec.result_valid = 1'b1;
          next_dec.result = {{HALF_W{src_a_val[HALF_W-1]}}, src_a_val[HALF_W-1:0]};
        end
      end
      OPC_SPR: begin
        if (low1 == LOW_FROM_SPR) begin
          next_dec.result_valid = 1'b1;
          next_dec.result = (s1_instr[SPR_BIT] == SPR_MSW) ? msw_out : s1_pc;
        end
      end
      OPC_JUMP: begin
        next_dec.branch_taken = 1'b1;
        next_dec.delay_slot = srca1[JMP_DLY_BIT];
        next_dec.branch_target = srca1[JMP_ABS_BIT] ? src_b_val : s1_pc + src_b_val;
        next_dec.result_valid = srca1[JMP_LINK_BIT];
        next_dec.result = s1_pc;
      end
      OPC_CBR: begin
        next_dec.branch_taken = cond_true;
        next_dec.delay_slot = dst1[CBR_DLY_BIT];
        next_dec.branch_target = s1_pc + src_b_val;
      end
      OPC_RET: begin
        next_dec.branch_taken = 1'b1;
        next_dec.delay_slot = 1'b1;
        next_dec.branch_target = src_a_val + s1_imm;
      end
      default: begin
        if (opc1[5:4] == MEM_CLASS) begin
          next_dec.mem_valid = 1'b1;
          next_dec.mem_write = opc1[STORE_BIT];
          next_dec.mem_size = opc1[1:0];
          next_dec.mem_addr = src_a_val + next_dec.operand_b;
          if (opc1[1:0] == SIZE_HALF) begin
            next_dec.mem_addr = next_dec.mem_addr & MASK_HALF;
          end else if (opc1[1:0] == SIZE_WORD) begin
            next_dec.mem_addr = next_dec.mem_addr & MASK_WORD;
          end
        end
      end
    endcase
  end

  // Decoded result leaves through one register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dec_out <= '0;
    end else begin
      dec_out <= next_dec;
    end
  end

  // Status word: decoded effects override a carry update from execute
  always_comb begin
    next_msw = msw_out;
    if (carry_wr) begin
      next_msw[MSW_CARRY] = carry_val;
    end
    if (is_to_spr && s1_instr[SPR_BIT] == SPR_MSW) begin
      next_msw = src_a_val;
    end
    if (is_ret && dst1 == RET_INT) begin
      next_msw[MSW_INT_EN] = 1'b1;
    end
    if (is_ret && dst1 == RET_BRK) begin
      next_msw[MSW_BREAK_ACTIVE] = 1'b0;
    end
    next_msw[MSW_CC] = next_msw[MSW_CARRY];
  end

  // Status word register; a move-to takes effect on the next cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      msw_out <= MSW_RESET;
    end else begin
      msw_out <= next_msw;
    end
  end

  // Count of decoded instructions, prefixes excluded
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      decode_count <= '0;
    end else if (s1_valid) begin
      decode_count <= decode_count + 32'h0000_0001;
    end
  end

  // Bus address phase accepted on a selected, active transfer
  assign addr_ok = hsel && hready && htrans[1];
  assign a_off = haddr[REG_AW-1:0];
  assign ctrl_wr = dp_active && dp_write && dp_addr == REG_CTRL;
  // Forward a write in flight so a following read sees it
  assign ctrl_view = ctrl_wr ? (hwdata & CTRL_MASK) : ctrl;

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (a_off)
      REG_CTRL: next_rdata = ctrl_view;
      REG_MSW: next_rdata = msw_out;
      REG_COUNT: next_rdata = decode_count;
      REG_PREFIX: next_rdata = {15'h0000, pfx_pending, pfx_value};
      default: next_rdata = '0;
    endcase
  end

  // Data phase bookkeeping; zero wait states, always OKAY
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      dp_active <= 1'b0;
      dp_write <= 1'b0;
      dp_addr <= '0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      if (hready) begin
        dp_active <= addr_ok;
        dp_write <= hwrite;
        dp_addr <= a_off;
      end
      if (addr_ok && !hwrite) begin
        hrdata <= next_rdata;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Control register, written in the data phase
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= hwdata & CTRL_MASK;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  property p_sign_ext;
    s1_valid && fmt1 && !s1_pfx_used |=>
      dec_out.operand_b == {{HALF_W{$past(s1_instr[HALF_W-1])}}, $past(s1_instr[HALF_W-1:0])};
  endproperty
  a_sign_ext: assert property (p_sign_ext) else $error("immediate not sign-extended");

  property p_prefix_join;
    s1_valid && fmt1 && s1_pfx_used |=> dec_out.operand_b[WORD_W-1:HALF_W] == $past(s1_pfx_val);
  endproperty
  a_prefix_join: assert property (p_prefix_join) else $error("prefix half not applied");

  property p_prefix_once;
    pfx_pending && take && instr_word[OPC_HI:OPC_LO] != OPC_PREFIX |=> !pfx_pending;
  endproperty
  a_prefix_once: assert property (p_prefix_once) else $error("prefix outlived follower");

  property p_reg_format;
    s1_valid && !fmt1 |=> !dec_out.imm_valid && dec_out.operand_b == $past(src_b_val) &&
      dec_out.src_b_sel == $past(s1_instr[SRCB_HI:SRCB_LO]);
  endproperty
  a_reg_format: assert property (p_reg_format) else $error("register format operand wrong");

  property p_widen;
    s1_valid && opc1 == OPC_SEXT && low1 == LOW_SEXT |=> dec_out.result_valid &&
      dec_out.result == {{HALF_W{$past(src_a_val[HALF_W-1])}}, $past(src_a_val[HALF_W-1:0])};
  endproperty
  a_widen: assert property (p_widen) else $error("halfword widen wrong");

  property p_link;
    s1_valid && opc1 == OPC_JUMP && srca1[JMP_LINK_BIT] |=>
      dec_out.branch_taken && dec_out.result_valid && dec_out.result == $past(s1_pc);
  endproperty
  a_link: assert property (p_link) else $error("link jump did not save counter");

  property p_int_return;
    is_ret && dst1 == RET_INT |=> msw_out[MSW_INT_EN] && dec_out.branch_taken;
  endproperty
  a_int_return: assert property (p_int_return) else $error("interrupt enable not set");

  property p_brk_return;
    is_ret && dst1 == RET_BRK |=> !msw_out[MSW_BREAK_ACTIVE];
  endproperty
  a_brk_return: assert property (p_brk_return) else $error("break flag not cleared");

  property p_carry;
    carry_wr && !is_to_spr |=> msw_out[MSW_CARRY] == $past(carry_val) &&
      msw_out[MSW_CC] == $past(carry_val);
  endproperty
  a_carry: assert property (p_carry) else $error("carry bit or copy wrong");

  property p_align;
    dec_out.mem_valid && dec_out.mem_size == SIZE_WORD |-> dec_out.mem_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("word access misaligned");

  c_prefix_used: cover property (s1_valid && s1_pfx_used ##1 dec_out.valid);
  c_int_return: cover property (is_ret && dst1 == RET_INT);
  c_cond_taken: cover property (s1_valid && opc1 == OPC_CBR && cond_true);
  c_bus_write: cover property (ctrl_wr ##1 !ctrl[CTRL_EN_BIT]);
endmodule

`default_nettype wire

// File: rtl/decoder_pkg.sv
// Shared constants and carrier types for the instruction decoder.
// Assumes a big-endian bit order: bit 0 of the word is index 31 here.
`default_nettype none

package decoder_pkg;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned SEL_W = 5;
  localparam int unsigned NUM_REGS = 32;
  localparam logic [SEL_W-1:0] ZERO_REG = 5'h00;

  // Field positions, index numbering (bit 0 of the word is 31)
  localparam int unsigned OPC_HI = 31;
  localparam int unsigned OPC_LO = 26;
  localparam int unsigned DST_HI = 25;
  localparam int unsigned DST_LO = 21;
  localparam int unsigned SRCA_HI = 20;
  localparam int unsigned SRCA_LO = 16;
  localparam int unsigned SRCB_HI = 15;
  localparam int unsigned SRCB_LO = 11;
  localparam int unsigned IMM_HI = 15;
  localparam int unsigned IMM_LO = 0;
  localparam int unsigned LOW_HI = 15;
  localparam int unsigned LOW_LO = 1;
  localparam int unsigned SPR_BIT = 0;
  localparam int unsigned FMT_BIT = 29;

  // Opcodes and low-field codes
  localparam logic [5:0] OPC_SEXT = 6'h24;
  localparam logic [5:0] OPC_SPR = 6'h25;
  localparam logic [5:0] OPC_JUMP = 6'h26;
  localparam logic [5:0] OPC_CBR = 6'h27;
  localparam logic [5:0] OPC_PREFIX = 6'h2c;
  localparam logic [5:0] OPC_RET = 6'h2d;
  localparam logic [1:0] MEM_CLASS = 2'h3;
  localparam int unsigned STORE_BIT = 2;
  localparam logic [14:0] LOW_SEXT = 15'h0061;
  localparam logic [14:0] LOW_TO_SPR = 15'h6000;
  localparam logic [14:0] LOW_FROM_SPR = 15'h4000;
  localparam logic SPR_PC = 1'h0;
  localparam logic SPR_MSW = 1'h1;

  // Jump, branch and return sub-fields
  localparam int unsigned JMP_DLY_BIT = 4;
  localparam int unsigned JMP_ABS_BIT = 3;
  localparam int unsigned JMP_LINK_BIT = 2;
  localparam int unsigned CBR_DLY_BIT = 4;
  localparam logic [2:0] CND_EQ = 3'h0;
  localparam logic [2:0] CND_NE = 3'h1;
  localparam logic [2:0] CND_LT = 3'h2;
  localparam logic [2:0] CND_LE = 3'h3;
  localparam logic [2:0] CND_GT = 3'h4;
  localparam logic [2:0] CND_GE = 3'h5;
  localparam logic [4:0] RET_SUB = 5'h10;
  localparam logic [4:0] RET_INT = 5'h11;
  localparam logic [4:0] RET_BRK = 5'h12;

  // Memory access sizes and address masks
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [31:0] MASK_HALF = 32'hffff_fffe;
  localparam logic [31:0] MASK_WORD = 32'hffff_fffc;

  // Machine status word layout
  localparam int unsigned MSW_CC = 31;
  localparam int unsigned MSW_BREAK_ACTIVE = 3;
  localparam int unsigned MSW_CARRY = 2;
  localparam int unsigned MSW_INT_EN = 1;
  localparam logic [31:0] MSW_RESET = 32'h0000_0000;

  // Bus register map
  localparam int unsigned REG_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MSW = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam logic [7:0] REG_PREFIX = 8'h0c;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [31:0] CTRL_MASK = 32'h0000_0001;
  localparam int unsigned PFX_PEND_BIT = 16;

  typedef logic [WORD_W-1:0] word_type;

  typedef struct packed {
    logic valid;
    logic imm_format;
    logic [5:0] opcode;
    logic [SEL_W-1:0] dst_sel;
    logic [SEL_W-1:0] src_a_sel;
    logic [SEL_W-1:0] src_b_sel;
    word_type operand_a;
    word_type operand_b;
    logic imm_valid;
    logic result_valid;
    word_type result;
    logic branch_taken;
    word_type branch_target;
    logic delay_slot;
    logic mem_valid;
    logic mem_write;
    logic [1:0] mem_size;
    word_type mem_addr;
  } decoded_type;
endpackage

`default_nettype wire

// File: rtl/imm_extend.sv
// Immediate widening: prefix join or sign extension of the low half.
// Assumes the caller supplies the prefix only while it is still pending.
`default_nettype none

module imm_extend import decoder_pkg::*; (
  input wire logic [HALF_W-1:0] imm_half,
  input wire logic pfx_pending,
  input wire logic [HALF_W-1:0] pfx_value,
  output logic [WORD_W-1:0] imm_full
);
  // Prefix supplies the upper half, else replicate the sign
  always_comb begin
    if (pfx_pending) begin
      imm_full = {pfx_value, imm_half};
    end else begin
      imm_full = {{HALF_W{imm_half[HALF_W-1]}}, imm_half};
    end
  end
endmodule

`default_nettype wire

// File: rtl/register_file.sv
// Thirty-two general-purpose registers, two read ports, one write port.
// Assumes one clock; read data come out of a register one cycle later.
`default_nettype none

module register_file import decoder_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [SEL_W-1:0] a_sel,
  input wire logic [SEL_W-1:0] b_sel,
  input wire logic wr_en,
  input wire logic [SEL_W-1:0] wr_sel,
  input wire logic [WORD_W-1:0] wr_data,
  output logic [WORD_W-1:0] a_data,
  output logic [WORD_W-1:0] b_data
);
  logic [WORD_W-1:0] mem [NUM_REGS];

  // Writes to the zero register are dropped
  always_ff @(posedge clk_sys) begin
    if (wr_en && wr_sel != ZERO_REG) begin
      mem[wr_sel] <= wr_data;
    end
  end

  // Read old contents on a same-cycle write; no bypass here
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      a_data <= '0;
      b_data <= '0;
    end else begin
      a_data <= (a_sel == ZERO_REG) ? '0 : mem[a_sel];
      b_data <= (b_sel == ZERO_REG) ? '0 : mem[b_sel];
    end
  end

  property p_zero_reg;
    @(posedge clk_sys) disable iff (!rstn)
    (a_sel == ZERO_REG) && (b_sel == ZERO_REG) |=> (a_data == '0) && (b_data == '0);
  endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("zero register read nonzero");
endmodule

`default_nettype wire

// File: tb/fetch_exec_model.sv
// Fetch and write-back side of the decoder: offers words, writes registers.
// Assumes one bench process calls the tasks; decoder package is compiled.
`default_nettype none

module fetch_exec_model import decoder_pkg::*; (
  input wire logic clk_sys,
  output logic instr_valid,
  output word_type instr_word,
  output word_type instr_pc,
  output logic wb_en,
  output logic [SEL_W-1:0] wb_sel,
  output word_type wb_data,
  output logic carry_wr,
  output logic carry_val
);
  timeunit 1ns;
  timeprecision 100ps;

  // Quiet start, all strobes low
  initial begin
    instr_valid = 1'b0;
    instr_word = 32'h0;
    instr_pc = 32'h0;
    wb_en = 1'b0;
    wb_sel = 5'h00;
    wb_data = 32'h0;
    carry_wr = 1'b0;
    carry_val = 1'b0;
  end

  // One word, then idle; returns once the decoded result is settled
  task automatic issue(input word_type w, input word_type pc);
    @(posedge clk_sys);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_pc <= pc;
    @(posedge clk_sys);
    instr_valid <= 1'b0;
    instr_word <= ~w;  // Stale word must never look valid
    instr_pc <= ~pc;
    @(posedge clk_sys);
    #1;
  endtask

  // Register write-back; an edge passes before the next strobe
  task automatic write_reg(input logic [SEL_W-1:0] s, input word_type val);
    @(posedge clk_sys);
    wb_en <= 1'b1;
    wb_sel <= s;
    wb_data <= val;
    @(posedge clk_sys);
    wb_en <= 1'b0;
    wb_data <= ~val;
  endtask

  // Carry update from execute, settled one edge later
  task automatic set_carry(input logic val);
    @(posedge clk_sys);
    carry_wr <= 1'b1;
    carry_val <= val;
    @(posedge clk_sys);
    carry_wr <= 1'b0;
    carry_val <= ~val;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the decoder stage and its bus registers.
// Assumes the fetch/write-back model; registers reached over AHB-Lite.
`default_nettype none

module testbench import decoder_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, rstn, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  wire logic instr_valid, wb_en, carry_wr, carry_val;
  wire word_type instr_word, instr_pc, wb_data;
  wire logic [SEL_W-1:0] wb_sel;
  decoded_type dec_out, d;
  word_type msw_out, v, cnt, ori, pfx, rw;
  word_type pc = 32'h0000_2000;
  int n_errors, cmp_count, cycles, k, c, r;
  word_type rv [8] = '{32'hdead_beef, 32'h1234_8765, 32'h0000_0100, 32'hffff_ffff,
                       32'h0, 32'h1, 32'h6, 32'h8};
  logic [5:0] tk [3] = '{6'b001110, 6'b101001, 6'b110010};  // Taken per cond, source one -1/0/1
  logic [4:0] jf [4] = '{5'h00, 5'h14, 5'h08, 5'h1c};
  word_type rm [3] = '{32'h0000_0008, 32'h0000_000a, 32'h0000_0002};
  logic [5:0] mo [2] = '{6'h32, 6'h35};
  logic [1:0] mz [2] = '{2'h2, 2'h1};
  word_type am [2] = '{32'hffff_fffc, 32'hffff_fffe};

  fetch_exec_model fx (
    .clk_sys(clk_sys), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .wb_en(wb_en), .wb_sel(wb_sel), .wb_data(wb_data),
    .carry_wr(carry_wr), .carry_val(carry_val)
  );

  risc_instruction_decoder uut (
    .clk_sys(clk_sys), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .wb_en(wb_en), .wb_sel(wb_sel), .wb_data(wb_data),
    .carry_wr(carry_wr), .carry_val(carry_val), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .dec_out(dec_out),
    .msw_out(msw_out)
  );

  // 200 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Single AHB-Lite word transfer; waits on hready, no fixed latency
  task automatic ahb(input logic wr, input logic [7:0] a, input word_type wd,
                     output word_type rd);
    @(posedge clk_sys);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input word_type e);
    ahb(1'b0, a, 32'h0, rw);
    chk(n, e, rw);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic run(input word_type w);
    fx.issue(w, pc);
    d = dec_out;
  endtask

  function automatic word_type enc(logic [5:0] op, logic [4:0] rd, logic [4:0] ra,
                                   logic [15:0] lo);
    return {op, rd, ra, lo};
  endfunction

  // Hang guard, generous against some 180 cycles of traffic
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      n_errors++;
      test_done();
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    rchk("ctrl", REG_CTRL, 32'h0000_0001);
    ahb(1'b1, REG_MSW, 32'hffff_ffff, v);
    rchk("msw ro", REG_MSW, 32'h0);
    ahb(1'b1, 8'h10, 32'hffff_ffff, v);
    rchk("unmapped", 8'h10, 32'h0);
    $display("test bus_regs done");
    for (k = 0; k < 8; k++) fx.write_reg(k[4:0], rv[k]);
    run(enc(6'h00, 5'h1f, 5'h00, 16'h0800));
    chk("valid", 32'h1, d.valid);
    chk("fmt", 32'h0, d.imm_format);
    chk("dst", 32'h1f, d.dst_sel);
    chk("srcb", 32'h1, d.src_b_sel);
    chk("r0", 32'h0, d.operand_a);
    chk("opb", rv[1], d.operand_b);
    chk("immv", 32'h0, d.imm_valid);
    $display("test reg_format done");
    ori = enc(6'h28, 5'h03, 5'h05, 16'h8001);
    pfx = enc(OPC_PREFIX, 5'h00, 5'h00, 16'habcd);
    run(ori);
    chk("imm fmt", 32'h1, d.imm_format);
    chk("imm srcb", 32'h0, d.src_b_sel);
    chk("imm opa", rv[5], d.operand_a);
    chk("imm srca", 32'h5, d.src_a_sel);
    chk("imm opc", 32'h28, d.opcode);
    chk("sext imm", 32'hffff_8001, d.operand_b);
    run(pfx);
    chk("prefix quiet", 32'h0, d.valid);
    rchk("prefix reg", REG_PREFIX, 32'h0001_abcd);
    run(ori);
    chk("joined", 32'habcd_8001, d.operand_b);
    run(ori);
    chk("once", 32'hffff_8001, d.operand_b);
    run(pfx);
    run(enc(6'h00, 5'h01, 5'h01, 16'h0800));
    run(ori);
    chk("dropped", 32'hffff_8001, d.operand_b);
    $display("test immediates done");
    run(enc(OPC_SEXT, 5'h0a, 5'h01, 16'h00c2));
    chk("widen", {{16{rv[1][15]}}, rv[1][15:0]}, d.result);
    run(enc(OPC_SPR, 5'h00, 5'h06, 16'hc001));
    chk("msw write", 32'h8000_0006, msw_out);
    run(enc(OPC_SPR, 5'h08, 5'h00, 16'h8001));
    chk("read msw", 32'h8000_0006, d.result);
    run(enc(OPC_SPR, 5'h08, 5'h00, 16'h8000));
    chk("read pc", pc, d.result);
    fx.set_carry(1'b0);
    chk("carry", 32'h0000_0002, msw_out);
    rchk("msw bus", REG_MSW, 32'h0000_0002);
    $display("test specials done");
    run(enc(OPC_SPR, 5'h00, 5'h07, 16'hc001));
    for (k = 0; k < 3; k++) begin
      run(enc(OPC_RET, 5'h10 + k[4:0], 5'h02, 16'hfff0));
      chk("ret", 32'h1, d.branch_taken);
      chk("ret tgt", 32'h0000_00f0, d.branch_target);
      chk("ret dly", 32'h1, d.delay_slot);
      chk("ret msw", rm[k], msw_out);
    end
    for (k = 0; k < 4; k++) begin
      run(enc(OPC_JUMP, 5'h09, jf[k], 16'h1000));
      chk("jump", 32'h1, d.branch_taken);
      chk("jtgt", jf[k][3] ? rv[2] : pc + rv[2], d.branch_target);
      chk("jdly", {31'h0, jf[k][4]}, d.delay_slot);
      chk("jlink", {31'h0, jf[k][2]}, d.result_valid);
      if (jf[k][2]) chk("link", pc, d.result);
    end
    for (r = 0; r < 3; r++) begin
      for (c = 0; c < 6; c++) begin
        run(enc(OPC_CBR, {r[0], 1'b0, c[2:0]}, 5'h03 + r[4:0], 16'h1000));
        chk("cond", {31'h0, tk[r][c]}, d.branch_taken);
        chk("cdly", {31'h0, r[0]}, d.delay_slot);
        if (tk[r][c]) chk("ctgt", pc + rv[2], d.branch_target);
      end
    end
    $display("test branches done");
    for (k = 0; k < 2; k++) begin
      run(enc(mo[k], 5'h04, 5'h01, 16'h3000));
      chk("mem", 32'h1, d.mem_valid);
      chk("mwr", k, d.mem_write);
      chk("msz", {30'h0, mz[k]}, d.mem_size);
      chk("maddr", (rv[1] + rv[6]) & am[k], d.mem_addr);
    end
    ahb(1'b0, REG_COUNT, 32'h0, cnt);
    ahb(1'b1, REG_CTRL, 32'h0, v);
    run(ori);
    chk("gated", 32'h0, d.valid);
    ahb(1'b1, REG_CTRL, 32'h1, v);
    run(ori);
    chk("enabled", 32'h1, d.valid);
    rchk("count", REG_COUNT, cnt + 32'h1);
    $display("test memory_and_gate done");
    test_done();
  end
endmodule

`default_nettype wire
